/* File: inc/rpnos_pkg.sv */
// Package for the operand stack: data widths, command codes and carrier structs
package rpnos_pkg;

  localparam int DATA_W   = 32;
  localparam int LN_STEPS = 21;
  localparam int SQRT_ITER = DATA_W / 2;

  // Values after reset and fixed results of the signum function
  localparam logic [DATA_W-1:0] RST_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SGN_POS   = 32'h0000_0001;
  localparam logic [DATA_W-1:0] SGN_ZERO  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SGN_NEG   = 32'hffff_ffff;

  // Powers of e rounded up, index k holds e^(k+1); for an integer magnitude
  // floor(ln|x|) is the count of entries it reaches, so rounding down would overcount
  localparam logic [DATA_W-1:0] EXP_TABLE [LN_STEPS] = '{
    32'h0000_0003, 32'h0000_0008, 32'h0000_0015, 32'h0000_0037,
    32'h0000_0095, 32'h0000_0194, 32'h0000_0449, 32'h0000_0ba5,
    32'h0000_1fa8, 32'h0000_560b, 32'h0000_e9e3, 32'h0002_7bc3,
    32'h0006_c02e, 32'h0012_59ad, 32'h0031_e19a, 32'h0087_975f,
    32'h0170_9349, 32'h03e9_e442, 32'h0aa3_6c7d, 32'h1ceb_088c,
    32'h4e9b_87f7
  };

  typedef enum logic [3:0] {
    RPNOS_DIGIT,
    RPNOS_ENTER,
    RPNOS_ROLL,
    RPNOS_SWAP,
    RPNOS_CLEAR_ALL_CMD,
    RPNOS_SIGNUM_FN,
    RPNOS_MAGNITUDE_FN,
    RPNOS_SQRT_FN,
    RPNOS_NATURAL_LOG_FN
  } rpnos_op_type;

  typedef struct packed {
    logic              valid;
    rpnos_op_type      op;
    logic [DATA_W-1:0] data;
  } rpnos_cmd_type;

  typedef struct packed {
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] t;
    logic [DATA_W-1:0] z;
    logic [DATA_W-1:0] y;
    logic [DATA_W-1:0] x;
  } rpnos_stack_type;

  typedef struct packed {
    logic negative_root_warning;
    logic log_domain_warning;
  } rpnos_warn_type;

endpackage : rpnos_pkg

/* File: tb/rpn_operand_stack_tb_top.sv */
// Self-checking bench comparing the operand stack with a reference model
`timescale 1ns/1ps
module rpn_operand_stack_tb_top import rpnos_pkg::*;;
  logic              CLK;
  logic              RESETN;
  rpnos_cmd_type     CMD;
  rpnos_stack_type   STACK;
  logic              ENTRY;
  rpnos_warn_type    WARN;
  logic [DATA_W-1:0] m [5];
  logic              ent;
  logic [1:0]        ew;
  logic              chk_on;
  int                n_mismatch;
  int                n_compared;
  int                cyc = 0;
  logic [DATA_W-1:0] vals [7] = '{32'h14, 32'hffff_ffec, 32'h0, 32'hffff_ffe7, 32'h8,
                                  32'hffff_fff8, 32'h8000_0000};
  rpnos_op_type      fns [4] = '{RPNOS_SIGNUM_FN, RPNOS_MAGNITUDE_FN, RPNOS_SQRT_FN,
                                 RPNOS_NATURAL_LOG_FN};

  rpnos_decoder_model i_rpnos_decoder_model (.clk(CLK), .cmd(CMD));
  rpnos_stack i_rpnos_stack (.CLK(CLK), .RESETN(RESETN), .CMD(CMD), .STACK(STACK),
                             .ENTRY(ENTRY), .WARN(WARN));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Reference update, applied at the edge that takes the command
  task automatic apply(input rpnos_op_type op, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] r;
    longint            s;
    a = m[4][DATA_W-1] ? -m[4] : m[4];
    r = '0;
    ew = 2'b00;
    if ((op == RPNOS_DIGIT || op == RPNOS_ENTER) && !ent)
      for (int i = 0; i < 4; i++) m[i] = m[i+1];
    case (op)
      RPNOS_DIGIT: m[4] = d;
      RPNOS_ROLL: begin
        r = m[4];
        for (int i = 4; i > 0; i--) m[i] = m[i-1];
        m[0] = r;
      end
      RPNOS_SWAP: begin
        r = m[4];
        m[4] = m[3];
        m[3] = r;
      end
      RPNOS_CLEAR_ALL_CMD: m = '{default: '0};
      RPNOS_SIGNUM_FN: m[4] = ($signed(m[4]) > 0) ? 32'h1 : ((m[4] == 0) ? 32'h0 : 32'hffff_ffff);
      RPNOS_MAGNITUDE_FN: m[4] = a;
      RPNOS_SQRT_FN: begin
        for (int b = 15; b >= 0; b--) begin
          s = r | (longint'(1) << b);
          if (s * s <= a) r = s[31:0];
        end
        ew[1] = m[4][DATA_W-1];
        m[4] = r;
      end
      RPNOS_NATURAL_LOG_FN: begin
        ew[0] = ($signed(m[4]) <= 0);
        m[4] = (a == 0) ? '0 : DATA_W'(int'($floor($ln(real'(a)))));
      end
      default: ;
    endcase
    ent = (op == RPNOS_DIGIT);
  endtask : apply

  task automatic issue(input rpnos_op_type op, input logic [DATA_W-1:0] d);
    i_rpnos_decoder_model.send(op, d);
    apply(op, d);
  endtask : issue

  // Outputs are looked at mid-cycle, once the taking edge has settled
  always @(negedge CLK) begin
    if (chk_on) begin
      check(STACK.w, m[0]);
      check(STACK.t, m[1]);
      check(STACK.z, m[2]);
      check(STACK.y, m[3]);
      check(STACK.x, m[4]);
      check({31'h0, ENTRY}, {31'h0, ent});
      check({30'h0, WARN}, {30'h0, ew});
    end
  end

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic go_idle();
    i_rpnos_decoder_model.idle();
    ew = 2'b00;
  endtask : go_idle

  initial begin
    RESETN = 1'b0;
    chk_on = 1'b0;
    m = '{default: '0};
    ent = 1'b0;
    ew = 2'b00;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(34));
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    chk_on = 1'b1;
    for (int k = 1; k <= 5; k++) begin
      issue(RPNOS_DIGIT, DATA_W'(k));
      if (k < 5) issue(RPNOS_ENTER, '0);
    end
    repeat (5) issue(RPNOS_ROLL, '0);
    repeat (2) issue(RPNOS_SWAP, '0);
    issue(RPNOS_ENTER, '0);
    issue(RPNOS_DIGIT, 32'h2d);
    issue(RPNOS_DIGIT, 32'h1c2);
    issue(RPNOS_CLEAR_ALL_CMD, '0);
    foreach (vals[i]) begin
      foreach (fns[j]) begin
        issue(RPNOS_DIGIT, vals[i]);
        issue(fns[j], '0);
      end
    end
    issue(RPNOS_ENTER, '0);
    // Random mix of every code except the slow log path
    repeat (40) issue(rpnos_op_type'($urandom_range(0, 7)), $urandom);
    go_idle();
    repeat (2) go_idle();
    // Second reset in mid-run clears the stack at once
    RESETN <= 1'b0;
    m = '{default: '0};
    ent = 1'b0;
    ew = 2'b00;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    issue(RPNOS_DIGIT, 32'h7);
    go_idle();
    final_report();
  end
endmodule : rpn_operand_stack_tb_top

/* File: tb/rpnos_decoder_model.sv */
// Command decoder model that presents keypad commands to the stack
`timescale 1ns/1ps
module rpnos_decoder_model
  import rpnos_pkg::*;
(
  input  wire logic     clk,  // System clock
  output rpnos_cmd_type cmd   // Command toward the stack
);
  initial cmd = '0;
  // Held for one edge; back-to-back calls keep valid high with no gap
  task automatic send(input rpnos_op_type op, input logic [DATA_W-1:0] data);
    cmd <= '{1'b1, op, data};
    @(posedge clk);
  endtask : send
  // Released bus carries a changing pattern, never the last value
  task automatic idle();
    cmd <= '{1'b0, RPNOS_ENTER, $urandom};
    @(posedge clk);
  endtask : idle
endmodule : rpnos_decoder_model

/* File: verilog/rpnos_stack.sv */
// Five-register operand stack W T Z Y X with entry state and unary functions
//
// What this block does
// - Rotate moves every value one register right; X wraps into W.
// - Exchange swaps X and Y only; doing it twice restores them.
// - Clear-all loads zero into all five stack registers.
// - First digit of a number pushes the stack, writes X, starts entry.
// - Enter during numeric entry only ends entry, no push.
// - Enter outside numeric entry pushes, duplicating X into Y.
// - Single-operand functions change only X.
// - Signum gives 1, 0 or -1 for positive, zero, negative X.
// - Magnitude function drops the sign of X.
// - Square root of negative X warns and roots the magnitude.
// - Natural log warns when X is zero or negative.
// - Digits right after a function start new entry, pushing result to Y.
`timescale 1ns/1ps
module rpnos_stack
  import rpnos_pkg::*;
(
  input  wire logic            CLK,       // System clock, 100 MHz
  input  wire logic            RESETN,    // Asynchronous reset, active low
  input  wire rpnos_cmd_type   CMD,       // Command from the keypad decoder
  output rpnos_stack_type      STACK,     // Current W T Z Y X contents
  output logic                 ENTRY,     // High while a number is being keyed
  output rpnos_warn_type       WARN       // One-cycle warning pulses
);

  logic            rst_meta_q;
  logic            rst_sync_q;
  rpnos_stack_type stk_q;
  rpnos_stack_type stk_d;
  logic            entry_q;
  logic            entry_d;
  rpnos_warn_type  warn_q;
  rpnos_warn_type  warn_d;

  // Reset enters asynchronously but releases through two flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire             cmd_go   = CMD.valid;
  wire             is_digit = cmd_go && (CMD.op == RPNOS_DIGIT);
  wire             is_enter = cmd_go && (CMD.op == RPNOS_ENTER);
  wire             is_roll  = cmd_go && (CMD.op == RPNOS_ROLL);
  wire             is_swap  = cmd_go && (CMD.op == RPNOS_SWAP);
  wire             is_clear = cmd_go && (CMD.op == RPNOS_CLEAR_ALL_CMD);
  wire             is_unary = cmd_go && ((CMD.op == RPNOS_SIGNUM_FN)
                                      || (CMD.op == RPNOS_MAGNITUDE_FN)
                                      || (CMD.op == RPNOS_SQRT_FN)
                                      || (CMD.op == RPNOS_NATURAL_LOG_FN));
  // Push happens at entry start, or on enter outside entry
  wire             do_push  = (is_digit && !entry_q) || (is_enter && !entry_q);

  wire [DATA_W-1:0] fn_result;
  rpnos_warn_type   fn_warn;

  rpnos_unary u_unary (
    .x_val  (stk_q.x),
    .op     (CMD.op),
    .result (fn_result),
    .warn   (fn_warn)
  );

  wire rpnos_stack_type pushed  = '{w: stk_q.t, t: stk_q.z, z: stk_q.y,
                                    y: stk_q.x, x: stk_q.x};
  wire rpnos_stack_type rolled  = '{w: stk_q.x, t: stk_q.w, z: stk_q.t,
                                    y: stk_q.z, x: stk_q.y};
  wire rpnos_stack_type swapped = '{w: stk_q.w, t: stk_q.t, z: stk_q.z,
                                    y: stk_q.x, x: stk_q.y};
  wire rpnos_stack_type applied = '{w: stk_q.w, t: stk_q.t, z: stk_q.z,
                                    y: stk_q.y, x: fn_result};

  always_comb begin
    stk_d   = stk_q;
    entry_d = entry_q;
    warn_d  = '0;
    if (is_digit) begin
      stk_d   = entry_q ? stk_q : pushed;
      // The decoder resends the whole number, so X is simply overwritten
      stk_d.x = CMD.data;
      entry_d = 1'b1;
    end else if (is_enter) begin
      stk_d   = entry_q ? stk_q : pushed;
      entry_d = 1'b0;
    end else if (is_roll) begin
      stk_d   = rolled;
      entry_d = 1'b0;
    end else if (is_swap) begin
      stk_d   = swapped;
      entry_d = 1'b0;
    end else if (is_clear) begin
      stk_d   = '0;
      entry_d = 1'b0;
    end else if (is_unary) begin
      stk_d   = applied;
      warn_d  = fn_warn;
      entry_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      stk_q   <= '0;
      entry_q <= 1'b0;
      warn_q  <= '0;
    end else begin
      stk_q   <= stk_d;
      entry_q <= entry_d;
      warn_q  <= warn_d;
    end
  end

  assign STACK = stk_q;
  assign ENTRY = entry_q;
  assign WARN  = warn_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_sync_q);

  // Magnitude of X and squares of X, kept apart from the function unit so that
  // the value checks below do not reuse the logic they judge
  wire [DATA_W-1:0]   x_mag   = stk_q.x[DATA_W-1] ? (32'h0000_0000 - stk_q.x) : stk_q.x;
  wire [2*DATA_W-1:0] root_sq = {32'h0000_0000, stk_q.x} * {32'h0000_0000, stk_q.x};
  wire [2*DATA_W-1:0] next_sq = ({32'h0000_0000, stk_q.x} + 64'h0000_0000_0000_0001)
                              * ({32'h0000_0000, stk_q.x} + 64'h0000_0000_0000_0001);

  chk_roll_shift: assert property (
    is_roll |=> (STACK.w == $past(stk_q.x)) && (STACK.t == $past(stk_q.w))
             && (STACK.z == $past(stk_q.t)) && (STACK.y == $past(stk_q.z))
             && (STACK.x == $past(stk_q.y)))
    else $error("Roll did not rotate X into W");

  chk_swap_xy: assert property (
    is_swap |=> (STACK.x == $past(stk_q.y)) && (STACK.y == $past(stk_q.x))
             && (STACK.w == $past(stk_q.w)) && (STACK.z == $past(stk_q.z)))
    else $error("Exchange did not swap X and Y alone");

  chk_clear_zero: assert property (
    is_clear |=> (STACK == '0))
    else $error("Clear left a nonzero register");

  chk_entry_push: assert property (
    (is_digit && !ENTRY) |=> ENTRY && (STACK.x == $past(CMD.data))
                          && (STACK.y == $past(stk_q.x)))
    else $error("First digit did not push and load X");

  chk_enter_nopush: assert property (
    (is_enter && ENTRY) |=> !ENTRY && $stable(STACK))
    else $error("Enter during entry changed the stack");

  chk_enter_dup: assert property (
    (is_enter && !ENTRY) |=> (STACK.y == STACK.x) && (STACK.x == $past(stk_q.x))
                          && (STACK.w == $past(stk_q.t)))
    else $error("Enter outside entry did not duplicate X");

  chk_unary_xonly: assert property (
    is_unary |=> (STACK.y == $past(stk_q.y)) && (STACK.w == $past(stk_q.w))
              && (STACK.z == $past(stk_q.z)) && (STACK.t == $past(stk_q.t))
              && !ENTRY)
    else $error("Unary function touched a register other than X");

  chk_signum_val: assert property (
    (is_unary && (CMD.op == RPNOS_SIGNUM_FN))
        |=> (STACK.x == (($past(stk_q.x) == '0) ? SGN_ZERO
                         : ($past(stk_q.x[DATA_W-1]) ? SGN_NEG : SGN_POS))))
    else $error("Signum result does not follow the sign of X");

  chk_magnitude_val: assert property (
    (is_unary && (CMD.op == RPNOS_MAGNITUDE_FN)) |=> (STACK.x == $past(x_mag)))
    else $error("Magnitude function did not drop the sign of X");

  // The root is judged by its defining bounds rather than by a second root circuit
  chk_sqrt_floor: assert property (
    (is_unary && (CMD.op == RPNOS_SQRT_FN))
        |=> (root_sq <= {32'h0000_0000, $past(x_mag)})
         && (next_sq > {32'h0000_0000, $past(x_mag)}))
    else $error("Square root is not the floor root of the magnitude");

  chk_sqrt_warn: assert property (
    (is_unary && (CMD.op == RPNOS_SQRT_FN)) |=> (WARN.negative_root_warning
                                                == $past(stk_q.x[DATA_W-1])))
    else $error("Negative root warning mismatch");

  chk_log_warn: assert property (
    (is_unary && (CMD.op == RPNOS_NATURAL_LOG_FN)) |=> (WARN.log_domain_warning
        == ($past(stk_q.x[DATA_W-1]) || ($past(stk_q.x) == RST_VALUE))))
    else $error("Log domain warning mismatch");

  chk_fn_newentry: assert property (
    (is_unary ##1 (is_digit)) |=> (STACK.y == $past(stk_q.x)) && ENTRY)
    else $error("Digit after function did not push the result");

  chk_push_chain: assert property (
    do_push |=> (STACK.w == $past(stk_q.t)) && (STACK.t == $past(stk_q.z))
             && (STACK.z == $past(stk_q.y)))
    else $error("Push did not move T Z Y down one place");

  chk_entry_digit: assert property (
    (is_digit && ENTRY) |=> ENTRY && (STACK.x == $past(CMD.data))
                         && (STACK.y == $past(stk_q.y)) && (STACK.w == $past(stk_q.w)))
    else $error("Digit during entry pushed the stack");

  chk_warn_pulse: assert property (
    !is_unary |=> (WARN == '0))
    else $error("Warning raised without a function command");

  // Without a command the stack must not move, or a push could slip in unseen
  chk_idle_hold: assert property (
    !cmd_go |=> $stable(STACK) && $stable(ENTRY))
    else $error("Stack changed with no command");

  cov_roll_five: cover property (is_roll [*5]);
  cov_enter_twice: cover property (is_enter ##1 is_enter);
  cov_sqrt_neg: cover property (WARN.negative_root_warning);
  cov_fn_then_digit: cover property (is_unary ##1 is_digit);
  cov_log_warn: cover property (WARN.log_domain_warning);

endmodule : rpnos_stack

/* File: verilog/rpnos_unary.sv */
// Single-operand function unit: signum, magnitude, square root and natural log on X
`timescale 1ns/1ps
module rpnos_unary
  import rpnos_pkg::*;
(
  input  wire logic [DATA_W-1:0] x_val,      // Signed operand
  input  wire rpnos_op_type      op,         // Selected function
  output logic      [DATA_W-1:0] result,     // Replacement for X
  output rpnos_warn_type         warn        // Domain warnings for this operand
);

  logic [DATA_W-1:0] mag;
  logic [DATA_W-1:0] root;
  logic [DATA_W-1:0] logv;
  logic              is_neg;
  logic              is_zero;

  assign is_neg  = x_val[DATA_W-1];
  assign is_zero = (x_val == RST_VALUE);
  // Most negative value has no positive twin; it stays as an unsigned magnitude
  assign mag     = is_neg ? (~x_val + 32'h0000_0001) : x_val;

  // Bitwise integer square root, result rounded down
  always_comb begin
    logic [DATA_W-1:0] rem;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] bitv;
    rem  = mag;
    res  = RST_VALUE;
    bitv = 32'h4000_0000;
    for (int i = 0; i < SQRT_ITER; i++) begin
      if (rem >= (res | bitv)) begin
        rem = rem - (res | bitv);
        res = (res >> 1) | bitv;
      end else begin
        res = res >> 1;
      end
      bitv = bitv >> 2;
    end
    root = res;
  end

  // Floor of ln of the magnitude; a zero operand yields zero
  always_comb begin
    logv = RST_VALUE;
    for (int k = 0; k < LN_STEPS; k++) begin
      if (mag >= EXP_TABLE[k]) begin
        logv = logv + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    result = x_val;
    warn   = '0;
    unique case (op)
      RPNOS_SIGNUM_FN: begin
        result = is_zero ? SGN_ZERO : (is_neg ? SGN_NEG : SGN_POS);
      end
      RPNOS_MAGNITUDE_FN: begin
        result = mag;
      end
      RPNOS_SQRT_FN: begin
        result                     = root;
        warn.negative_root_warning = is_neg;
      end
      RPNOS_NATURAL_LOG_FN: begin
        result                  = logv;
        warn.log_domain_warning = is_neg | is_zero;
      end
      default: begin
        result = x_val;
      end
    endcase
  end

endmodule : rpnos_unary
